/* isp_pkg.sv */
`default_nettype none

package isp_pkg;

	// ---------------------------------------------------------------
	// Register offsets on the special function register port.
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CHIP_CTRL = 8'h9f;
	localparam logic [7:0] ADDR_TRIGGER   = 8'ha4;
	localparam logic [7:0] ADDR_ADDR_LO   = 8'ha6;
	localparam logic [7:0] ADDR_ADDR_HI   = 8'ha7;
	localparam logic [7:0] ADDR_DATA      = 8'hae;
	localparam logic [7:0] ADDR_CMD       = 8'haf;
	localparam logic [7:0] ADDR_TA_KEY    = 8'hc7;

	// ---------------------------------------------------------------
	// Timed access key bytes and field positions.
	// ---------------------------------------------------------------
	localparam logic [7:0] TA_KEY_FIRST  = 8'haa;
	localparam logic [7:0] TA_KEY_SECOND = 8'h55;
	localparam int         CC_PE_BIT     = 0;
	localparam int         CC_LUEN_BIT   = 5;
	localparam int         CC_FAULT_BIT  = 6;
	localparam int         LAUNCH_BIT    = 0;
	localparam int         CMD_CE_BIT    = 4;
	localparam int         CMD_OE_BIT    = 5;
	localparam int         CMD_REG_LSB   = 6;

	// ---------------------------------------------------------------
	// Command encodings and target regions.
	// ---------------------------------------------------------------
	localparam logic [3:0] ACT_ERASE     = 4'h2;
	localparam logic [3:0] ACT_PROG      = 4'h1;
	localparam logic [3:0] ACT_READ      = 4'h0;
	localparam logic [1:0] REGION_MAIN   = 2'h0;
	localparam logic [1:0] REGION_LOADER = 2'h1;
	localparam logic [1:0] REGION_CONFIG = 2'h3;

	// ---------------------------------------------------------------
	// Sizes, reset values and timing.
	// ---------------------------------------------------------------
	localparam logic [16:0] MAIN_BYTES      = 17'h10000;
	localparam logic [16:0] LOADER_BYTES    = 17'h01000;
	localparam logic [15:0] CFG_LAST_ADDR   = 16'h0003;
	localparam int          CFG_COUNT       = 4;
	localparam logic [7:0]  CFG_ERASED      = 8'hff;
	localparam int          BOOT_SEL_BIT    = 7;
	localparam logic [7:0]  REG_RESET       = 8'h00;
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          CFG_OP_TIME_NS  = 5000;
	localparam logic [11:0] CFG_OP_CYCLES   =
		12'((CFG_OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ---------------------------------------------------------------
	// Types.
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT_OSC, ST_FLASH, ST_CFG} isp_state_t;
	typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_PROG, OP_READ} isp_op_t;

	typedef struct packed {
		isp_op_t     op;
		logic [1:0]  region;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} isp_flash_cmd_t;

	typedef struct packed {
		isp_state_t          state;
		logic [7:0]          cmd;
		logic [7:0]          addr_hi;
		logic [7:0]          addr_lo;
		logic [7:0]          data;
		logic                pe;
		logic                luen;
		logic                fault;
		logic [1:0]          ta_stage;
		logic [11:0]         cfg_cnt;
		logic                req_pulse;
		logic [7:0]          rdata;
		logic [3:0][7:0]     cfg_store;
		logic [3:0][7:0]     cfg_active;
	} isp_regs_t;

endpackage : isp_pkg

`default_nettype wire

/* isp_flash_seq.sv */
// Overview of operation
// R1 - Data register holds program or read byte.
// R2 - Launch bit starts operation and stalls CPU.
// R3 - Completion clears launch, releases CPU; reads zero.
// R4 - Decode action from enables and action code.
// R5 - Upper address bits pick target region; the code takes it from cmd bits 7:6 instead.
// R6 - Page erase works on 256-byte pages.
// R7 - Config erase clears all; bytes 0-3 addressed.
// R8 - Operations need oscillator; enable gates triggering.
// R9 - Software clears enable using timed access.
// R10 - External code fetch refuses operation, sets fault.
// R11 - Config access only from loader code.
// R12 - New config applies after reset; boot bit special.
// R13 - Security lock never blocks sequencer operations.
// R14 - Both areas may read themselves.
// R15 - Software disables interrupts while programming.
// R16 - Software updates config bytes last.
// R17 - Illegal accesses and oversize set sticky fault.
// R18 - Loader update enable gates loader writes.
// R19 - Address from high and low registers.
// R20 - Protected writes need key pair first.
`timescale 1ns/10ps
`default_nettype none

module isp_flash_seq (
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire logic [7:0]              sfr_addr,
	input  wire logic [7:0]              sfr_wdata,
	input  wire logic                    sfr_wr,
	input  wire logic                    sfr_rd,
	output logic [7:0]                   sfr_rdata,
	input  wire logic                    running_from_loader,
	input  wire logic                    fetch_external,
	input  wire logic                    osc_ready,
	output logic                         rc_osc_en,
	output logic                         cpu_stall,
	output logic                         flash_req,
	output isp_pkg::isp_flash_cmd_t      flash_cmd,
	input  wire logic                    flash_done,
	input  wire logic [7:0]              flash_rdata,
	input  wire logic                    cfg_reload,
	input  wire logic                    reset_was_sw,
	output logic [31:0]                  config_active
);

	// ---------------------------------------------------------------
	// Helpers.
	// ---------------------------------------------------------------

	// Standby and any unlisted code decode to no operation.
	function automatic isp_pkg::isp_op_t decode_op(input logic [7:0] cmd);
		isp_pkg::isp_op_t op;
		op = isp_pkg::OP_NONE;
		if (cmd[isp_pkg::CMD_OE_BIT] && !cmd[isp_pkg::CMD_CE_BIT]) begin
			if (cmd[3:0] == isp_pkg::ACT_ERASE) // R4
				op = isp_pkg::OP_ERASE;
			else if (cmd[3:0] == isp_pkg::ACT_PROG) // R4
				op = isp_pkg::OP_PROG;
		end else if (!cmd[isp_pkg::CMD_OE_BIT] && !cmd[isp_pkg::CMD_CE_BIT]
			&& cmd[3:0] == isp_pkg::ACT_READ) begin
			op = isp_pkg::OP_READ; // R4
		end
		return op;
	endfunction : decode_op

	// The lock bit is deliberately not an input here, so it cannot block. R13
	function automatic logic is_illegal(
		input isp_pkg::isp_op_t op,
		input logic [1:0]       region,
		input logic [15:0]      addr,
		input logic             from_loader,
		input logic             luen,
		input logic             ext_fetch
	);
		logic wr;
		logic bad;
		wr  = (op == isp_pkg::OP_ERASE) || (op == isp_pkg::OP_PROG);
		bad = ext_fetch; // R10
		case (region) // R5
			isp_pkg::REGION_MAIN: begin
				// Reads are fine from either area; only writes to the running area fault. R14
				if (wr && !from_loader) // R17
					bad = 1'b1;
				if ({1'b0, addr} >= isp_pkg::MAIN_BYTES) // R17
					bad = 1'b1;
			end
			isp_pkg::REGION_LOADER: begin
				if (wr && from_loader) // R17
					bad = 1'b1;
				if (wr && !from_loader && !luen) // R18
					bad = 1'b1;
				if ({1'b0, addr} >= isp_pkg::LOADER_BYTES) // R17
					bad = 1'b1;
			end
			isp_pkg::REGION_CONFIG: begin
				if (!from_loader) // R11
					bad = 1'b1;
				if (op == isp_pkg::OP_ERASE && addr[15:8] != 8'h00) // R7
					bad = 1'b1;
				if (op != isp_pkg::OP_ERASE && addr > isp_pkg::CFG_LAST_ADDR) // R7
					bad = 1'b1;
			end
			default: begin
				bad = 1'b1;
			end
		endcase
		return bad;
	endfunction : is_illegal

	// ---------------------------------------------------------------
	// State.
	// ---------------------------------------------------------------
	isp_pkg::isp_regs_t  s_ff;
	isp_pkg::isp_regs_t  nxt_s;
	isp_pkg::isp_op_t    cur_op;
	logic [15:0]         cur_addr;
	logic [1:0]          cur_region;
	logic                prot_ok;
	logic                launch_try;
	logic                launch_bad;

	// Operation fields come straight from the registers, which the stalled CPU cannot change.
	assign cur_op     = decode_op(s_ff.cmd);
	assign cur_addr   = {s_ff.addr_hi, s_ff.addr_lo}; // R19
	assign cur_region = s_ff.cmd[7:isp_pkg::CMD_REG_LSB]; // R5
	assign prot_ok    = sfr_wr && s_ff.ta_stage == 2'h2 && sfr_addr != isp_pkg::ADDR_TA_KEY; // R20
	// Without the programming enable a trigger write has no effect at all. R8
	assign launch_try = prot_ok && sfr_addr == isp_pkg::ADDR_TRIGGER
		&& sfr_wdata[isp_pkg::LAUNCH_BIT] && s_ff.pe && s_ff.state == isp_pkg::ST_IDLE;
	assign launch_bad = is_illegal(cur_op, cur_region, cur_addr, running_from_loader,
		s_ff.luen, fetch_external);

	// ---------------------------------------------------------------
	// Next-state logic.
	// ---------------------------------------------------------------

	// Register writes first, then the sequencer, so a hardware fault set wins a clear.
	always_comb begin
		logic [1:0] idx;
		idx             = s_ff.addr_lo[1:0];
		nxt_s           = s_ff;
		nxt_s.req_pulse = 1'b0;
		nxt_s.rdata     = 8'h00;

		// Key pair arms exactly the next write; any other write disarms. R20
		if (sfr_wr) begin
			if (sfr_addr == isp_pkg::ADDR_TA_KEY) begin
				if (sfr_wdata == isp_pkg::TA_KEY_FIRST)
					nxt_s.ta_stage = 2'h1;
				else if (s_ff.ta_stage == 2'h1 && sfr_wdata == isp_pkg::TA_KEY_SECOND)
					nxt_s.ta_stage = 2'h2;
				else
					nxt_s.ta_stage = 2'h0;
			end else begin
				nxt_s.ta_stage = 2'h0;
			end
		end

		// Plain register writes.
		if (sfr_wr) begin
			case (sfr_addr)
				isp_pkg::ADDR_CMD:     nxt_s.cmd = sfr_wdata;
				isp_pkg::ADDR_ADDR_HI: nxt_s.addr_hi = sfr_wdata; // R19
				isp_pkg::ADDR_ADDR_LO: nxt_s.addr_lo = sfr_wdata; // R19
				isp_pkg::ADDR_DATA:    nxt_s.data = sfr_wdata; // R1
				default: begin
				end
			endcase
		end

		// Unkeyed writes to chip control are dropped silently. R9
		if (prot_ok && sfr_addr == isp_pkg::ADDR_CHIP_CTRL) begin // R20
			nxt_s.pe    = sfr_wdata[isp_pkg::CC_PE_BIT]; // R8
			nxt_s.luen  = sfr_wdata[isp_pkg::CC_LUEN_BIT]; // R18
			nxt_s.fault = sfr_wdata[isp_pkg::CC_FAULT_BIT]; // R17
		end

		// Sequencer.
		case (s_ff.state)
			isp_pkg::ST_IDLE: begin
				if (launch_try && cur_op != isp_pkg::OP_NONE) begin
					if (launch_bad)
						nxt_s.fault = 1'b1; // R17
					else
						nxt_s.state = isp_pkg::ST_WAIT_OSC; // R2
				end
			end
			isp_pkg::ST_WAIT_OSC: begin
				// The oscillator must be running before any flash timing starts. R8
				if (osc_ready) begin
					if (cur_region == isp_pkg::REGION_CONFIG) begin
						nxt_s.state   = isp_pkg::ST_CFG;
						nxt_s.cfg_cnt = isp_pkg::CFG_OP_CYCLES - 12'h001;
					end else begin
						nxt_s.state     = isp_pkg::ST_FLASH;
						nxt_s.req_pulse = 1'b1;
					end
				end
			end
			isp_pkg::ST_FLASH: begin
				if (flash_done) begin
					if (cur_op == isp_pkg::OP_READ)
						nxt_s.data = flash_rdata; // R1
					nxt_s.state = isp_pkg::ST_IDLE; // R3
				end
			end
			isp_pkg::ST_CFG: begin
				if (s_ff.cfg_cnt == 12'h000) begin
					case (cur_op)
						isp_pkg::OP_ERASE: begin
							for (int i = 0; i < isp_pkg::CFG_COUNT; i++) begin
								nxt_s.cfg_store[i] = isp_pkg::CFG_ERASED; // R7
							end
						end
						isp_pkg::OP_PROG: nxt_s.cfg_store[idx] = s_ff.data; // R7
						isp_pkg::OP_READ: nxt_s.data = s_ff.cfg_store[idx]; // R7
						default: begin
						end
					endcase
					nxt_s.state = isp_pkg::ST_IDLE; // R3
				end else begin
					nxt_s.cfg_cnt = s_ff.cfg_cnt - 12'h001;
				end
			end
			default: begin
				nxt_s.state = isp_pkg::ST_IDLE;
			end
		endcase

		// Stored config takes effect only when the system reset logic says so.
		if (cfg_reload) begin
			nxt_s.cfg_active = s_ff.cfg_store; // R12
			if (reset_was_sw) // R12
				nxt_s.cfg_active[0][isp_pkg::BOOT_SEL_BIT] =
					s_ff.cfg_active[0][isp_pkg::BOOT_SEL_BIT];
		end

		// Read data stands for exactly the cycle after the strobe.
		if (sfr_rd) begin
			case (sfr_addr)
				isp_pkg::ADDR_CHIP_CTRL: begin
					nxt_s.rdata[isp_pkg::CC_PE_BIT]    = s_ff.pe;
					nxt_s.rdata[isp_pkg::CC_LUEN_BIT]  = s_ff.luen;
					nxt_s.rdata[isp_pkg::CC_FAULT_BIT] = s_ff.fault;
				end
				isp_pkg::ADDR_TRIGGER: nxt_s.rdata = 8'h00; // R3
				isp_pkg::ADDR_CMD:     nxt_s.rdata = s_ff.cmd;
				isp_pkg::ADDR_ADDR_HI: nxt_s.rdata = s_ff.addr_hi;
				isp_pkg::ADDR_ADDR_LO: nxt_s.rdata = s_ff.addr_lo;
				isp_pkg::ADDR_DATA:    nxt_s.rdata = s_ff.data; // R1
				default:               nxt_s.rdata = 8'h00;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// State register.
	// ---------------------------------------------------------------

	// Config storage resets to erased; a real part would keep it, this model cannot.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_ff            <= '0;
			s_ff.cmd        <= isp_pkg::REG_RESET;
			s_ff.data       <= isp_pkg::REG_RESET;
			s_ff.cfg_store  <= {isp_pkg::CFG_COUNT{isp_pkg::CFG_ERASED}};
			s_ff.cfg_active <= {isp_pkg::CFG_COUNT{isp_pkg::CFG_ERASED}};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ---------------------------------------------------------------
	// Outputs.
	// ---------------------------------------------------------------

	// Erase always targets the page base, so a stray low byte cannot shift it.
	always_comb begin
		flash_cmd.op     = cur_op;
		flash_cmd.region = cur_region;
		flash_cmd.addr   = cur_addr;
		flash_cmd.wdata  = s_ff.data;
		if (cur_op == isp_pkg::OP_ERASE)
			flash_cmd.addr[7:0] = 8'h00; // R6
	end

	assign sfr_rdata     = s_ff.rdata;
	assign rc_osc_en     = s_ff.pe; // R8
	assign cpu_stall     = s_ff.state != isp_pkg::ST_IDLE; // R2
	assign flash_req     = s_ff.req_pulse;
	assign config_active = s_ff.cfg_active;

	// ---------------------------------------------------------------
	// Assertions.
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	chk_launch_stalls: assert property ( // R2
		launch_try && cur_op != isp_pkg::OP_NONE && !launch_bad |=> cpu_stall [*2])
		else $error("Legal launch did not stall the CPU.");
	chk_trigger_needs_pe: assert property ( // R8
		s_ff.state == isp_pkg::ST_IDLE && !s_ff.pe |=> !cpu_stall)
		else $error("Sequencer started without programming enable.");
	chk_trigger_reads_zero: assert property ( // R3
		sfr_rd && sfr_addr == isp_pkg::ADDR_TRIGGER |=> sfr_rdata == 8'h00)
		else $error("Trigger register did not read as zero.");
	chk_stall_release: assert property ( // R3
		s_ff.state == isp_pkg::ST_FLASH && flash_done |=> !cpu_stall)
		else $error("CPU still stalled after flash completion.");
	chk_read_capture: assert property ( // R1
		s_ff.state == isp_pkg::ST_FLASH && flash_done && cur_op == isp_pkg::OP_READ
		|=> s_ff.data == $past(flash_rdata))
		else $error("Read byte not captured in data register.");
	chk_fault_set: assert property ( // R17
		launch_try && cur_op != isp_pkg::OP_NONE && launch_bad |=> s_ff.fault && !cpu_stall)
		else $error("Illegal launch did not fault.");
	chk_ext_refused: assert property ( // R10
		launch_try && fetch_external |=> !cpu_stall)
		else $error("Launch from external code was not refused.");
	chk_unkeyed_ignored: assert property ( // R20
		sfr_wr && sfr_addr == isp_pkg::ADDR_CHIP_CTRL && s_ff.ta_stage != 2'h2
		|=> s_ff.pe == $past(s_ff.pe) && s_ff.luen == $past(s_ff.luen))
		else $error("Unkeyed chip control write took effect.");
	chk_erase_page: assert property ( // R6
		flash_req && flash_cmd.op == isp_pkg::OP_ERASE |-> flash_cmd.addr[7:0] == 8'h00)
		else $error("Page erase address not page aligned.");
	chk_cfg_bounded: assert property ( // R7
		$rose(s_ff.state == isp_pkg::ST_CFG) |-> ##[1:501] s_ff.state == isp_pkg::ST_IDLE)
		else $error("Config operation overran its time.");
	chk_boot_bit_kept: assert property ( // R12
		cfg_reload && reset_was_sw |=> config_active[isp_pkg::BOOT_SEL_BIT]
		== $past(config_active[isp_pkg::BOOT_SEL_BIT]))
		else $error("Boot select changed on software reset.");
	chk_loader_locked: assert property ( // R18
		launch_try && cur_region == isp_pkg::REGION_LOADER && !running_from_loader
		&& !s_ff.luen && cur_op == isp_pkg::OP_PROG |=> s_ff.fault)
		else $error("Loader write without update enable.");

	cov_flash_read: cover property (
		s_ff.state == isp_pkg::ST_FLASH && flash_done && cur_op == isp_pkg::OP_READ);
	cov_cfg_prog: cover property (
		s_ff.state == isp_pkg::ST_CFG && s_ff.cfg_cnt == 12'h000
		&& cur_op == isp_pkg::OP_PROG);
	cov_fault: cover property ($rose(s_ff.fault));

endmodule : isp_flash_seq

`default_nettype wire

/* isp_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// Flash macro model on the far side of the sequencer.
// ---------------------------------------------------------------
module isp_flash_model (
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire logic                    slow,
	input  wire logic                    flash_req,
	input  wire isp_pkg::isp_flash_cmd_t flash_cmd,
	output logic                         flash_done,
	output logic [7:0]                   flash_rdata
);
	logic [7:0]              mem [logic [17:0]];
	isp_pkg::isp_flash_cmd_t cmd_ff;
	logic [17:0]             key;
	int                      cnt;

	assign key = {cmd_ff.region, cmd_ff.addr};

	// Answers after one or twenty cycles; cells never written read ff.
	// The read byte toggles outside the done pulse so a late sample fails.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt <= 0;
			flash_done <= 1'b0;
			flash_rdata <= 8'h5a;
		end else begin
			flash_done <= 1'b0;
			flash_rdata <= ~flash_rdata;
			if (flash_req) begin
				cmd_ff <= flash_cmd;
				cnt <= slow ? 20 : 1;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end else if (cnt == 1) begin
				cnt <= 0;
				flash_done <= 1'b1;
				case (cmd_ff.op)
				isp_pkg::OP_ERASE: for (int i = 0; i < 256; i++) begin
						mem.delete({cmd_ff.region, cmd_ff.addr[15:8], 8'(i)});
					end
				isp_pkg::OP_PROG: mem[key] = cmd_ff.wdata;
				isp_pkg::OP_READ: flash_rdata <= mem.exists(key) ? mem[key] : 8'hff;
				default: ;
				endcase
			end
		end
	end
endmodule : isp_flash_model

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end

module tb_top;
	// ---------------------------------------------------------------
	// Stimulus, instances and counters.
	// ---------------------------------------------------------------
	logic                    clk = 1'b0;
	logic                    reset = 1'b1;
	logic [7:0]              sfr_addr = 8'h00;
	logic [7:0]              sfr_wdata = 8'h00;
	logic                    sfr_wr = 1'b0;
	logic                    sfr_rd = 1'b0;
	logic [7:0]              sfr_rdata;
	logic                    running_from_loader = 1'b1;
	logic                    fetch_external = 1'b0;
	logic                    osc_ready = 1'b0;
	logic                    rc_osc_en;
	logic                    cpu_stall;
	logic                    flash_req;
	isp_pkg::isp_flash_cmd_t flash_cmd;
	logic                    flash_done;
	logic [7:0]              flash_rdata;
	logic                    cfg_reload = 1'b0;
	logic                    reset_was_sw = 1'b0;
	logic [31:0]             config_active;
	logic                    slow = 1'b0;
	int                      n_errors = 0;
	int                      samples_checked = 0;
	int                      seed = 9;
	logic [7:0]              v;
	logic [7:0]              cc;
	logic [15:0]             ra;
	logic [7:0]              rdat;
	logic [7:0]              rst_addrs [8] = '{isp_pkg::ADDR_CHIP_CTRL, isp_pkg::ADDR_TRIGGER,
		isp_pkg::ADDR_ADDR_LO, isp_pkg::ADDR_ADDR_HI, isp_pkg::ADDR_DATA, isp_pkg::ADDR_CMD,
		isp_pkg::ADDR_TA_KEY, 8'h10};

	isp_flash_seq uut (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.running_from_loader(running_from_loader), .fetch_external(fetch_external),
		.osc_ready(osc_ready), .rc_osc_en(rc_osc_en), .cpu_stall(cpu_stall),
		.flash_req(flash_req), .flash_cmd(flash_cmd), .flash_done(flash_done),
		.flash_rdata(flash_rdata), .cfg_reload(cfg_reload), .reset_was_sw(reset_was_sw),
		.config_active(config_active));

	isp_flash_model u_flash (.clk(clk), .reset(reset), .slow(slow), .flash_req(flash_req),
		.flash_cmd(flash_cmd), .flash_done(flash_done), .flash_rdata(flash_rdata));

	// Clock, and an oscillator that comes up one cycle after its enable.
	always #5 clk = ~clk;
	always @(posedge clk) osc_ready <= rc_osc_en;

	// An erase must reach the macro page aligned whatever the low byte held.
	always @(posedge clk) if (flash_req && flash_cmd.op == isp_pkg::OP_ERASE) begin
		`CHK(flash_cmd.addr[7:0], 8'h00)
	end

	// ---------------------------------------------------------------
	// Bus tasks and expectations.
	// ---------------------------------------------------------------
	function automatic logic [7:0] mk(input logic [1:0] rg, input logic oe, input logic ce,
		input logic [3:0] code);
		return {rg, oe, ce, code};
	endfunction : mk

	task automatic complete_run();
		if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1 d = sfr_rdata;
	endtask : rd

	// Protected write: the key pair has to come directly before it.
	task automatic kw(input logic [7:0] a, input logic [7:0] d);
		wr(isp_pkg::ADDR_TA_KEY, isp_pkg::TA_KEY_FIRST);
		wr(isp_pkg::ADDR_TA_KEY, isp_pkg::TA_KEY_SECOND);
		wr(a, d);
	endtask : kw

	// The bench raises no interrupt while an operation holds the CPU.
	task automatic op(input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d,
		input logic stall);
		int n;
		wr(isp_pkg::ADDR_CMD, cmd);
		wr(isp_pkg::ADDR_ADDR_HI, a[15:8]);
		wr(isp_pkg::ADDR_ADDR_LO, a[7:0]);
		wr(isp_pkg::ADDR_DATA, d);
		kw(isp_pkg::ADDR_TRIGGER, 8'h01);
		#1 `CHK(cpu_stall, stall)
		n = 0;
		while (cpu_stall !== 1'b0) begin
			@(posedge clk);
			#1 n++;
			if (n > 2000) begin
				n_errors++;
				complete_run();
			end
		end
	endtask : op

	task automatic chkreg(input logic [7:0] a, input logic [7:0] e);
		rd(a, v);
		`CHK(v, e)
	endtask : chkreg

	// Reads the fault flag and clears it with a keyed write when set.
	task automatic fault(input logic e);
		rd(isp_pkg::ADDR_CHIP_CTRL, v);
		`CHK(v[isp_pkg::CC_FAULT_BIT], e)
		if (v[isp_pkg::CC_FAULT_BIT]) kw(isp_pkg::ADDR_CHIP_CTRL, cc);
	endtask : fault

	task automatic reload(input logic sw);
		@(posedge clk);
		cfg_reload <= 1'b1;
		reset_was_sw <= sw;
		@(posedge clk);
		cfg_reload <= 1'b0;
		@(posedge clk);
	endtask : reload

	// ---------------------------------------------------------------
	// Main sequence.
	// ---------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		foreach (rst_addrs[i]) begin
			chkreg(rst_addrs[i], 8'h00);
		end
		`CHK(config_active, 32'hffffffff)
		wr(isp_pkg::ADDR_CHIP_CTRL, 8'h01);
		wr(isp_pkg::ADDR_TRIGGER, 8'h01);
		#1 `CHK({rc_osc_en, cpu_stall}, 2'b00)
		cc = 8'h01;
		kw(isp_pkg::ADDR_CHIP_CTRL, cc);
		#1 `CHK(rc_osc_en, 1'b1)
		op(mk(2'h0, 1'b1, 1'b0, 4'h2), 16'h1234, 8'h00, 1'b1);
		op(mk(2'h0, 1'b0, 1'b0, 4'h0), 16'h12c7, 8'h00, 1'b1);
		chkreg(isp_pkg::ADDR_DATA, 8'hff);
		// Random program and read back in both regions, prompt and slow. Loader writes come
		// from application code with updates enabled; each read is an area reading itself.
		cc = 8'h21;
		kw(isp_pkg::ADDR_CHIP_CTRL, cc);
		for (int i = 0; i < 12; i++) begin
			ra = 16'($random(seed));
			rdat = 8'($random(seed));
			slow <= ra[0];
			ra[15:12] = i[0] ? 4'h0 : ra[15:12];
			running_from_loader <= !i[0];
			op(mk({1'b0, i[0]}, 1'b1, 1'b0, 4'h1), ra, rdat, 1'b1);
			running_from_loader <= i[0];
			op(mk({1'b0, i[0]}, 1'b0, 1'b0, 4'h0), ra, ~rdat, 1'b1);
			chkreg(isp_pkg::ADDR_DATA, rdat);
			chkreg(isp_pkg::ADDR_TRIGGER, 8'h00);
		end
		cc = 8'h01;
		kw(isp_pkg::ADDR_CHIP_CTRL, cc);
		op(8'h30, 16'h0000, 8'h00, 1'b0);
		fault(1'b0);
		running_from_loader <= 1'b0;
		op(mk(2'h0, 1'b1, 1'b0, 4'h1), 16'h0100, 8'h11, 1'b0);
		fault(1'b1);
		op(mk(2'h3, 1'b0, 1'b0, 4'h0), 16'h0000, 8'h00, 1'b0);
		fault(1'b1);
		op(mk(2'h1, 1'b1, 1'b0, 4'h1), 16'h0010, 8'h77, 1'b0);
		fault(1'b1);
		cc = 8'h21;
		kw(isp_pkg::ADDR_CHIP_CTRL, cc);
		op(mk(2'h1, 1'b1, 1'b0, 4'h1), 16'h0010, 8'h77, 1'b1);
		fault(1'b0);
		op(mk(2'h1, 1'b0, 1'b0, 4'h0), 16'h0010, 8'h00, 1'b1);
		chkreg(isp_pkg::ADDR_DATA, 8'h77);
		op(mk(2'h1, 1'b0, 1'b0, 4'h0), 16'h1000, 8'h00, 1'b0);
		fault(1'b1);
		running_from_loader <= 1'b1;
		op(mk(2'h2, 1'b0, 1'b0, 4'h0), 16'h0000, 8'h00, 1'b0);
		fault(1'b1);
		fetch_external <= 1'b1;
		op(mk(2'h0, 1'b0, 1'b0, 4'h0), 16'h0000, 8'h00, 1'b0);
		fault(1'b1);
		fetch_external <= 1'b0;
		// Configuration bytes come last: program, read, activate, erase, program again, activate.
		op(mk(2'h3, 1'b1, 1'b0, 4'h1), 16'h0003, 8'h3c, 1'b1);
		op(mk(2'h3, 1'b0, 1'b0, 4'h0), 16'h0003, 8'h00, 1'b1);
		chkreg(isp_pkg::ADDR_DATA, 8'h3c);
		reload(1'b0);
		`CHK(config_active[31:24], 8'h3c)
		op(mk(2'h3, 1'b0, 1'b0, 4'h0), 16'h0004, 8'h00, 1'b0);
		fault(1'b1);
		op(mk(2'h3, 1'b1, 1'b0, 4'h2), 16'h0100, 8'h00, 1'b0);
		fault(1'b1);
		op(mk(2'h3, 1'b1, 1'b0, 4'h2), 16'h0055, 8'h00, 1'b1);
		op(mk(2'h3, 1'b0, 1'b0, 4'h0), 16'h0003, 8'h00, 1'b1);
		chkreg(isp_pkg::ADDR_DATA, 8'hff);
		op(mk(2'h3, 1'b1, 1'b0, 4'h1), 16'h0000, 8'h00, 1'b1);
		reload(1'b1);
		`CHK(config_active, 32'hffffff80)
		reload(1'b0);
		`CHK(config_active[7:0], 8'h00)
		op(mk(2'h1, 1'b0, 1'b0, 4'h0), 16'h0010, 8'h00, 1'b1);
		chkreg(isp_pkg::ADDR_DATA, 8'h77);
		cc = 8'h00;
		kw(isp_pkg::ADDR_CHIP_CTRL, cc);
		#1 `CHK(rc_osc_en, 1'b0)
		op(mk(2'h0, 1'b0, 1'b0, 4'h0), 16'h0000, 8'h00, 1'b0);
		complete_run();
	end
endmodule : tb_top

`default_nettype wire
